/* logic/vcas_pkg.sv */
/*
  Shared constants for the VC-3 to 34 368 kbit/s adaptation sink:
  container bit layout, label check, elastic store, clock smoothing,
  client framing, all-ONEs detection and the register map.
  Assumes a bit-serial container stream, one bit per link clock edge.
*/
package vcas_pkg;
  // Container layout: 9 rows of 680 bits, counted from the frame start bit
  localparam logic [3:0]  LAST_ROW    = 4'h8;
  localparam logic [9:0]  LAST_COL    = 10'h2A7;
  localparam logic [9:0]  POH_END     = 10'h008;
  localparam logic [9:0]  RSV_END     = 10'h010;
  localparam logic [3:0]  LABEL_ROW   = 4'h2;
  localparam logic [9:0]  C1_COL      = 10'h010;
  localparam logic [9:0]  C2_COL      = 10'h011;
  localparam logic [3:0]  JC_LAST_ROW = 4'h4;
  localparam int          JC_BITS     = 5;
  localparam logic [2:0]  JC_MAJ      = 3'h3;
  localparam logic [3:0]  S_ROW       = 4'h8;
  localparam logic [9:0]  S1_COL      = 10'h010;
  localparam logic [9:0]  S2_COL      = 10'h011;

  // Kinds of container bit
  localparam logic [2:0]  BT_DATA  = 3'h0;
  localparam logic [2:0]  BT_SKIP  = 3'h1;
  localparam logic [2:0]  BT_LABEL = 3'h2;
  localparam logic [2:0]  BT_C1    = 3'h3;
  localparam logic [2:0]  BT_C2    = 3'h4;
  localparam logic [2:0]  BT_S1    = 3'h5;
  localparam logic [2:0]  BT_S2    = 3'h6;

  // Signal label
  localparam logic [7:0]  EXP_LABEL    = 8'h04;
  localparam logic [2:0]  LABEL_ACCEPT = 3'h5;

  // Elastic store and read clock
  localparam int               ES_AW       = 7;
  localparam int               ES_DEPTH    = 1 << ES_AW;
  localparam logic [ES_AW+1:0] ES_HALF     = 9'h040;
  localparam longint           REF_CLK_KHZ = 125000;
  localparam longint           CLIENT_KHZ  = 34368;
  localparam logic [31:0]      NCO_NOM     = 32'((CLIENT_KHZ << 32) / REF_CLK_KHZ);
  localparam int               NCO_GAIN    = 9;

  // Client frame alignment
  localparam int          FAW_LEN   = 10;
  localparam logic [9:0]  FAW       = 10'h3D0;
  localparam int          CL_CNT_W  = 11;
  localparam logic [10:0] CL_LAST   = 11'h5FF;
  localparam logic [10:0] FAW_END   = 11'h009;
  localparam logic [2:0]  LOF_SET   = 3'h4;
  localparam logic [2:0]  SYNC_SET  = 3'h3;

  typedef enum logic [2:0] {
    FR_HUNT    = 3'b001,
    FR_CONFIRM = 3'b010,
    FR_SYNC    = 3'b100
  } vcas_fr_state_t;

  // All-ONEs detection: zero count, interval length, interval count
  localparam logic [2:0]  AIS_ZEROS     = 3'h4;
  localparam logic [10:0] AIS_INT_LAST  = 11'h5FF;
  localparam logic [2:0]  AIS_INTERVALS = 3'h5;

  // Register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  STATUS_ADDR = 8'h04;
  localparam logic [7:0]  LABEL_ADDR  = 8'h08;
  localparam logic [7:0]  JUST_ADDR   = 8'h0C;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam int          CTRL_ACT    = 0;
  localparam int          CTRL_REP    = 1;
  localparam int          ST_UNDER    = 9;
  localparam int          ST_OVER     = 10;
endpackage

/* logic/vcas_framer.sv */
/*
  Client frame aligner for the recovered 34 368 kbit/s stream.
  Assumes one bit per bit_tick pulse, all on ref_clk.
*/
module vcas_framer
  import vcas_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic bit_tick,
  input  wire logic bit_in,
  output logic      frame_start,
  output logic      lof_defect
);
  vcas_fr_state_t       state_reg;
  logic [FAW_LEN-1:0]   win_reg;
  logic [FAW_LEN-1:0]   win;
  logic [CL_CNT_W-1:0]  pos_reg;
  logic [CL_CNT_W-1:0]  pos;
  logic [2:0]           hit_reg;
  logic [2:0]           miss_reg;
  logic                 faw_ok;
  logic                 at_faw;

  assign win    = {win_reg[FAW_LEN-2:0], bit_in};
  assign faw_ok = (win == FAW);
  assign pos    = (pos_reg == CL_LAST) ? '0 : pos_reg + 1'b1;
  assign at_faw = (pos == FAW_END);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_reg <= '0;
    end else if (bit_tick) begin
      win_reg <= win;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg  <= FR_HUNT;
      pos_reg    <= '0;
      hit_reg    <= '0;
      miss_reg   <= '0;
      lof_defect <= 1'b1;
    end else if (bit_tick) begin
      pos_reg <= pos;
      case (state_reg)
        FR_HUNT: begin
          if (faw_ok) begin
            pos_reg   <= FAW_END;
            hit_reg   <= 3'h1;
            state_reg <= FR_CONFIRM;
          end
        end
        FR_CONFIRM: begin
          if (at_faw && !faw_ok) begin
            state_reg <= FR_HUNT;
          end else if (at_faw && hit_reg == SYNC_SET - 3'h1) begin
            state_reg  <= FR_SYNC;
            miss_reg   <= '0;
            lof_defect <= 1'b0;
          end else if (at_faw) begin
            hit_reg <= hit_reg + 3'h1;
          end
        end
        FR_SYNC: begin
          if (at_faw && faw_ok) begin
            miss_reg <= '0;
          end else if (at_faw && miss_reg == LOF_SET - 3'h1) begin
            state_reg  <= FR_HUNT;
            lof_defect <= 1'b1;
          end else if (at_faw) begin
            miss_reg <= miss_reg + 3'h1;
          end
        end
        default: begin
          state_reg <= FR_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= bit_tick && state_reg == FR_SYNC && pos == '0;
    end
  end
endmodule

/* logic/vcas_ais_det.sv */
/*
  All-ONEs detector on the recovered client stream.
  Assumes one bit per bit_tick pulse, all on ref_clk.
*/
module vcas_ais_det
  import vcas_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic bit_tick,
  input  wire logic bit_in,
  output logic      ais_defect
);
  logic [10:0] bit_cnt_reg;
  logic [2:0]  zero_cnt_reg;
  logic [2:0]  good_cnt_reg;
  logic [2:0]  zeros;
  logic        int_end;
  logic        int_good;

  // Saturate at the threshold; the exact count above it does not matter
  assign zeros    = (!bit_in && zero_cnt_reg != AIS_ZEROS) ? zero_cnt_reg + 3'h1 : zero_cnt_reg;
  assign int_end  = (bit_cnt_reg == AIS_INT_LAST);
  assign int_good = (zeros < AIS_ZEROS);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_reg  <= '0;
      zero_cnt_reg <= '0;
    end else if (bit_tick) begin
      bit_cnt_reg  <= int_end ? '0 : bit_cnt_reg + 11'h001;
      zero_cnt_reg <= int_end ? '0 : zeros;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      good_cnt_reg <= '0;
      ais_defect   <= 1'b0;
    end else if (bit_tick && int_end) begin
      if (!int_good) begin
        good_cnt_reg <= '0;
        ais_defect   <= 1'b0;
      end else if (good_cnt_reg == AIS_INTERVALS - 3'h1) begin
        ais_defect <= 1'b1;
      end else begin
        good_cnt_reg <= good_cnt_reg + 3'h1;
      end
    end
  end
endmodule

/* logic/vcas_sink.sv */
/*
  VC-3 to 34 368 kbit/s adaptation sink: container demapping, label
  check, elastic store with smoothed read clock, client framing, defect
  handling and an AHB-Lite register slave.
  Assumes the container stream arrives bit-serial on a link clock that
  ref_clk oversamples, and that the register master is the only one.
*/
// Function
// - Compare accepted label byte with 0x04; difference raises payload mismatch.
// - Ignore multiframe indicator byte and reserved bits.
// - First control majority 0 keeps first stuff bit as data, else drops it.
// - Second control majority 0 keeps second stuff bit as data, else drops it.
// - Write store with gapped clock, read with smoothed client-rate clock.
// - Store deep enough for +-20 ppm and input jitter.
// - After a frequency step, settle within a bounded time.
// - Inactive: send all ONEs and report no causes or defect status bits; server_fail_action still follows the defects.
// - Align to client frame and mark frame start.
// - Four wrong alignment words in a row lose alignment.
// - Three correct alignment words in a row regain alignment.
// - Candidate dropped if word missing in either of next two frames.
// - Frame loss set on four errors, cleared on three good words.
// - Detect all-ONEs alarm with 4 zeros, 1536 bits, 5 intervals.
// - Fail and insert actions follow mismatch, frame loss, alarm or trail fail.
// - Output switches to or from all ONEs within 250 us.
// - Client clock stays near nominal while all ONEs is sent.
// - Alarm cause needs alarm, no mismatch, no trail fail, reporting on.
// - Frame loss cause needs frame loss without alarm or mismatch.
module vcas_sink
  import vcas_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        vc_clk_in,
  input  wire logic        vc_data_in,
  input  wire logic        vc_fs_in,
  input  wire logic        trail_fail_in,
  output logic             client_data_out,
  output logic             client_clock_out,
  output logic             frame_start_marker,
  output logic             server_fail_action,
  output logic             payload_mismatch_cause,
  output logic             all_ones_alarm_cause,
  output logic             frame_loss_cause
);
  logic [3:0]          sync1_reg;
  logic [3:0]          sync2_reg;
  logic                clk_d_reg;
  logic                in_tick;
  logic                in_bit;
  logic                in_fs;
  logic                trail_fail;
  logic [3:0]          row_reg;
  logic [9:0]          col_reg;
  logic [3:0]          cur_row;
  logic [9:0]          cur_col;
  logic [2:0]          kind;
  logic [JC_BITS-1:0]  c1_reg;
  logic [JC_BITS-1:0]  c2_reg;
  logic                s1_data;
  logic                s2_data;
  logic [7:0]          lbl_sh_reg;
  logic [7:0]          lbl_cand_reg;
  logic [2:0]          lbl_cnt_reg;
  logic [7:0]          label_reg;
  logic [7:0]          lbl_new;
  logic [ES_DEPTH-1:0] es_mem;
  logic [ES_AW:0]      wr_ptr_reg;
  logic [ES_AW:0]      rd_ptr_reg;
  logic [ES_AW:0]      fill;
  logic                es_full;
  logic                es_empty;
  logic                wr_take;
  logic [ES_AW+1:0]    fill_err;
  logic [31:0]         nco_trim;
  logic [31:0]         nco_incr;
  logic [31:0]         nco_acc_reg;
  logic [32:0]         nco_sum;
  logic                rd_tick_reg;
  logic                rd_bit;
  logic                pm_defect;
  logic                lof_defect;
  logic                ais_defect;
  logic                fail_any;
  logic                insert_ones;
  logic                active_reg;
  logic                report_reg;
  logic                under_reg;
  logic                over_reg;
  logic [15:0]         neg_cnt_reg;
  logic [15:0]         pos_cnt_reg;
  logic                dp_wr_reg;
  logic [ADDR_W-1:0]   dp_addr_reg;
  logic                addr_ok;
  logic                clr_under;
  logic                clr_over;

  function automatic logic majority(input logic [JC_BITS-1:0] v);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < JC_BITS; i++) begin
      n = n + {2'b00, v[i]};
    end
    majority = (n >= JC_MAJ);
  endfunction

  function automatic logic [2:0] bit_kind(input logic [3:0] row, input logic [9:0] col);
    if (col < POH_END) begin
      bit_kind = (row == LABEL_ROW) ? BT_LABEL : BT_SKIP;
    end else if (col < RSV_END) begin
      bit_kind = BT_SKIP;
    end else if (row == S_ROW && col == S1_COL) begin
      bit_kind = BT_S1;
    end else if (row == S_ROW && col == S2_COL) begin
      bit_kind = BT_S2;
    end else if (row <= JC_LAST_ROW && col == C1_COL) begin
      bit_kind = BT_C1;
    end else if (row <= JC_LAST_ROW && col == C2_COL) begin
      bit_kind = BT_C2;
    end else begin
      bit_kind = BT_DATA;
    end
  endfunction

  // Link pins and trail fail come from another domain
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      clk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {trail_fail_in, vc_fs_in, vc_data_in, vc_clk_in};
      sync2_reg <= sync1_reg;
      clk_d_reg <= sync2_reg[0];
    end
  end

  assign in_tick    = sync2_reg[0] & ~clk_d_reg;
  assign in_bit     = sync2_reg[1];
  assign in_fs      = sync2_reg[2];
  assign trail_fail = sync2_reg[3];

  always_comb begin
    if (in_fs) begin
      cur_row = '0;
      cur_col = '0;
    end else if (col_reg == LAST_COL) begin
      cur_col = '0;
      cur_row = (row_reg == LAST_ROW) ? '0 : row_reg + 4'h1;
    end else begin
      cur_col = col_reg + 10'h001;
      cur_row = row_reg;
    end
  end

  assign kind = bit_kind(cur_row, cur_col);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      row_reg <= LAST_ROW;
      col_reg <= LAST_COL;
    end else if (in_tick) begin
      row_reg <= cur_row;
      col_reg <= cur_col;
    end
  end

  // Justification control bits, decided by majority before the stuff bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c1_reg <= '0;
      c2_reg <= '0;
    end else if (in_tick && kind == BT_C1) begin
      c1_reg <= {c1_reg[JC_BITS-2:0], in_bit};
    end else if (in_tick && kind == BT_C2) begin
      c2_reg <= {c2_reg[JC_BITS-2:0], in_bit};
    end
  end

  assign s1_data = !majority(c1_reg);
  assign s2_data = !majority(c2_reg);
  assign wr_take = in_tick && (kind == BT_DATA || (kind == BT_S1 && s1_data)
                   || (kind == BT_S2 && s2_data));

  // Justification statistics for software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neg_cnt_reg <= '0;
      pos_cnt_reg <= '0;
    end else if (in_tick && kind == BT_S2 && s1_data && s2_data) begin
      neg_cnt_reg <= neg_cnt_reg + 16'h0001;
    end else if (in_tick && kind == BT_S2 && !s1_data && !s2_data) begin
      pos_cnt_reg <= pos_cnt_reg + 16'h0001;
    end
  end

  // Label is accepted after equal values in consecutive frames
  assign lbl_new = {lbl_sh_reg[6:0], in_bit};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lbl_sh_reg   <= '0;
      lbl_cand_reg <= '0;
      lbl_cnt_reg  <= '0;
      label_reg    <= '0;
    end else if (in_tick && kind == BT_LABEL) begin
      lbl_sh_reg <= lbl_new;
      if (cur_col == POH_END - 10'h001) begin
        if (lbl_new != lbl_cand_reg) begin
          lbl_cand_reg <= lbl_new;
          lbl_cnt_reg  <= '0;
        end else if (lbl_cnt_reg == LABEL_ACCEPT - 3'h2) begin
          label_reg <= lbl_new;
        end else begin
          lbl_cnt_reg <= lbl_cnt_reg + 3'h1;
        end
      end
    end
  end

  assign pm_defect = (label_reg != EXP_LABEL);

  // Elastic store; one spare pointer bit tells full from empty
  assign fill     = wr_ptr_reg - rd_ptr_reg;
  assign es_full  = fill[ES_AW];
  assign es_empty = (fill == '0);

  always_ff @(posedge ref_clk) begin
    if (wr_take && !es_full) begin
      es_mem[wr_ptr_reg[ES_AW-1:0]] <= in_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
    end else if (wr_take && !es_full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_ptr_reg <= '0;
    end else if (rd_tick_reg && !es_empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Starved reads yield ONEs rather than repeating stale data
  assign rd_bit = es_empty ? 1'b1 : es_mem[rd_ptr_reg[ES_AW-1:0]];

  // Read clock: phase accumulator trimmed by store fill, so rate tracks
  // the far end; proportional only, so fill settles off centre
  assign fill_err = {1'b0, fill} - ES_HALF;
  assign nco_trim = {{(32 - ES_AW - 2){fill_err[ES_AW+1]}}, fill_err} << NCO_GAIN;
  assign nco_incr = insert_ones ? NCO_NOM : NCO_NOM + nco_trim;
  assign nco_sum  = {1'b0, nco_acc_reg} + {1'b0, nco_incr};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nco_acc_reg <= '0;
      rd_tick_reg <= 1'b0;
    end else begin
      nco_acc_reg <= nco_sum[31:0];
      rd_tick_reg <= nco_sum[32];
    end
  end

  assign client_clock_out = nco_acc_reg[31];

  // Slip flags: hardware set wins over a software clear
  assign clr_under = dp_wr_reg && dp_addr_reg == STATUS_ADDR && hwdata[ST_UNDER];
  assign clr_over  = dp_wr_reg && dp_addr_reg == STATUS_ADDR && hwdata[ST_OVER];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      under_reg <= 1'b0;
      over_reg  <= 1'b0;
    end else begin
      under_reg <= (rd_tick_reg && es_empty) || (under_reg && !clr_under);
      over_reg  <= (wr_take && es_full) || (over_reg && !clr_over);
    end
  end

  vcas_framer u_framer (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .bit_tick    (rd_tick_reg),
    .bit_in      (rd_bit),
    .frame_start (frame_start_marker),
    .lof_defect  (lof_defect)
  );

  vcas_ais_det u_ais_det (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .bit_tick   (rd_tick_reg),
    .bit_in     (rd_bit),
    .ais_defect (ais_defect)
  );

  assign fail_any    = pm_defect | lof_defect | ais_defect | trail_fail;
  assign insert_ones = fail_any | ~active_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      client_data_out <= 1'b1;
    end else if (rd_tick_reg) begin
      client_data_out <= insert_ones ? 1'b1 : rd_bit;
    end
  end

  // Causes are silent while the function is not active
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      server_fail_action     <= 1'b0;
      payload_mismatch_cause <= 1'b0;
      all_ones_alarm_cause   <= 1'b0;
      frame_loss_cause       <= 1'b0;
    end else begin
      server_fail_action     <= fail_any;
      payload_mismatch_cause <= active_reg & pm_defect & ~trail_fail;
      all_ones_alarm_cause   <= active_reg & ais_defect & ~pm_defect & ~trail_fail
                                & report_reg;
      frame_loss_cause       <= active_reg & lof_defect & ~ais_defect & ~pm_defect;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_ok = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= '0;
    end else if (hready) begin
      dp_wr_reg   <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD && addr_ok;
      dp_addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_reg <= 1'b0;
      report_reg <= 1'b0;
    end else if (dp_wr_reg && dp_addr_reg == CTRL_ADDR) begin
      active_reg <= hwdata[CTRL_ACT];
      report_reg <= hwdata[CTRL_REP];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= '0;
      if (addr_ok) begin
        case (haddr[ADDR_W-1:0])
          CTRL_ADDR: begin
            hrdata[CTRL_ACT] <= active_reg;
            hrdata[CTRL_REP] <= report_reg;
          end
          STATUS_ADDR: begin
            hrdata[ST_OVER:0] <= {over_reg, under_reg, 1'b0, fill};
            hrdata[31:24]     <= {1'b0, payload_mismatch_cause, all_ones_alarm_cause,
                                  frame_loss_cause, server_fail_action,
                                  {3{active_reg}} & {pm_defect, ais_defect, lof_defect}};
          end
          LABEL_ADDR: begin
            hrdata[7:0] <= label_reg;
          end
          JUST_ADDR: begin
            hrdata <= {pos_cnt_reg, neg_cnt_reg};
          end
          default: begin
            hrdata <= '0;
          end
        endcase
      end
    end
  end
endmodule

/* tb/vcas_sink_asserts.sv */
/*
  Port checker for vcas_sink: defect actions, causes, client clock.
  Assumes it is bound to vcas_sink and sees only its ports.
*/
module vcas_sink_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic trail_fail_in,
  input wire logic client_data_out,
  input wire logic client_clock_out,
  input wire logic frame_start_marker,
  input wire logic server_fail_action,
  input wire logic payload_mismatch_cause,
  input wire logic all_ones_alarm_cause,
  input wire logic frame_loss_cause
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Trail fail crosses two sync flops and the output register, so four cycles are just enough
  a_fail_trail: assert property (trail_fail_in [*4] |-> server_fail_action)
    else $error("trail fail without server fail");
  a_plm_masked: assert property (trail_fail_in [*5] |-> !payload_mismatch_cause)
    else $error("mismatch cause during trail fail");
  a_ais_masked: assert property (trail_fail_in [*5] |-> !all_ones_alarm_cause)
    else $error("alarm cause during trail fail");
  a_alarm_excl: assert property (all_ones_alarm_cause |-> !payload_mismatch_cause)
    else $error("alarm cause with mismatch");
  a_lof_excl: assert property (frame_loss_cause
    |-> !(payload_mismatch_cause || all_ones_alarm_cause))
    else $error("frame loss cause not exclusive");
  a_cause_fail: assert property ((frame_loss_cause || payload_mismatch_cause)
    |-> server_fail_action)
    else $error("cause without server fail");
  a_ones_fail: assert property (server_fail_action [*8] |-> client_data_out)
    else $error("data not all ones on fail");
  a_clk_high: assert property ($rose(client_clock_out) |-> ##[1:3] !client_clock_out)
    else $error("client clock high too long");
  a_clk_low: assert property ($fell(client_clock_out) |-> ##[1:3] client_clock_out)
    else $error("client clock low too long");
  a_fs_pulse: assert property (frame_start_marker |=> !frame_start_marker)
    else $error("frame start longer than a cycle");
endmodule

bind vcas_sink vcas_sink_asserts chk_i (
  .ref_clk(ref_clk), .rst(rst), .trail_fail_in(trail_fail_in),
  .client_data_out(client_data_out), .client_clock_out(client_clock_out),
  .frame_start_marker(frame_start_marker), .server_fail_action(server_fail_action),
  .payload_mismatch_cause(payload_mismatch_cause),
  .all_ones_alarm_cause(all_ones_alarm_cause), .frame_loss_cause(frame_loss_cause)
);

/* tb/vcas_vc_src.sv */
/*
  Far-end model: path termination sending a bit-serial container.
  Assumes the sink leaves reset before the first frame begins.
*/
module vcas_vc_src
  import vcas_pkg::*;
(
  output logic vc_clk,
  output logic vc_data,
  output logic vc_fs,
  input  logic ones
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned row;
  int unsigned col;

  initial begin
    vc_clk = 1'b0;
    vc_data = 1'b0;
    vc_fs = 1'b0;
    #403.3;
    forever for (row = 0; row <= LAST_ROW; row++) for (col = 0; col <= LAST_COL; col++) begin
      vc_fs = (row == 0) && (col == 0);
      // Control bits vote 1 with one dissenter; rest alternates with label 00, or is all ONEs while ones is high
      vc_data = ((col == C1_COL || col == C2_COL) && row <= JC_LAST_ROW) ? (row != 0) :
                (col[0] ^ row[0]) && !(row == LABEL_ROW && col < 8) || ones;
      #62.5 vc_clk = 1'b1;
      #62.5 vc_clk = 1'b0;
    end
  end
endmodule

/* tb/vcas_sink_bench.sv */
/*
  Bench for vcas_sink: register access, activation, defect causes and
  justification count over one container frame.
  Assumes vcas_vc_src drives the link side.
*/
module vcas_sink_bench
  import vcas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, trail_fail_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        vc_clk_in, vc_data_in, vc_fs_in, client_data_out, client_clock_out;
  logic        frame_start_marker, server_fail_action, payload_mismatch_cause;
  logic        all_ones_alarm_cause, frame_loss_cause, ones;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  vcas_sink uut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vc_clk_in(vc_clk_in),
    .vc_data_in(vc_data_in), .vc_fs_in(vc_fs_in), .trail_fail_in(trail_fail_in),
    .client_data_out(client_data_out), .client_clock_out(client_clock_out),
    .frame_start_marker(frame_start_marker), .server_fail_action(server_fail_action),
    .payload_mismatch_cause(payload_mismatch_cause),
    .all_ones_alarm_cause(all_ones_alarm_cause), .frame_loss_cause(frame_loss_cause)
  );
  vcas_vc_src src (.vc_clk(vc_clk_in), .vc_data(vc_data_in), .vc_fs(vc_fs_in), .ones(ones));

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    trail_fail_in = 1'b0;
    ones = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0040, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0, "unmapped write ignored");
    repeat (40) begin
      @(negedge ref_clk);
      chk(client_data_out, 32'h1, "ones while inactive");
    end
    chk(payload_mismatch_cause, 32'h0, "no cause while inactive");
    $display("test registers and inactive done");
    @(posedge ref_clk);
    bus(1'b1, CTRL_ADDR, 32'h3);
    repeat (10) @(posedge ref_clk);
    chk(payload_mismatch_cause, 32'h1, "label 00 mismatch");
    chk(server_fail_action, 32'h1, "server fail");
    chk(frame_loss_cause, 32'h0, "frame loss cause masked");
    chk(all_ones_alarm_cause, 32'h0, "alarm cause masked");
    chk(client_data_out, 32'h1, "ones inserted");
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h0D00_0000, 32'h0D00_0000, "status defects");
    trail_fail_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(payload_mismatch_cause, 32'h0, "cause masked by trail fail");
    trail_fail_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(payload_mismatch_cause, 32'h1, "cause back");
    $display("test defects done");
    bus(1'b0, JUST_ADDR, 32'h0);
    chk(rd, 32'h0, "no justification yet");
    // Both stuff bits sit in the last row; wait past them
    ones <= 1'b1;
    repeat (2400) @(posedge vc_clk_in);
    @(posedge ref_clk);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h0200_0000, 32'h0200_0000, "alarm on ones");
    chk(all_ones_alarm_cause, 32'h0, "alarm cause masked");
    ones <= 1'b0;
    repeat (3060) @(posedge vc_clk_in);
    repeat (8) @(posedge ref_clk);
    bus(1'b0, JUST_ADDR, 32'h0);
    chk(rd, 32'h0001_0000, "one positive justification");
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h0200_0000, 32'h0, "alarm cleared");
    $display("test justification done");
    bus(1'b1, CTRL_ADDR, 32'h0);
    repeat (10) @(posedge ref_clk);
    chk(payload_mismatch_cause, 32'h0, "cause off when inactive");
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h0700_0000, 32'h0, "status hidden when inactive");
    $display("test deactivate done");
    report_and_stop();
  end
endmodule
